// file: include/eits_pkg.sv
// Constants for the external interrupt edge time-stamp unit.
// Assumes a 16-bit register view carried on a 32-bit Wishbone data bus.
package eits_pkg;
	// Register indices as word addresses; byte address is index times four
	localparam logic [15:0] EITS_IDX_IRQ1_CTRL  = 16'h7070;
	localparam logic [15:0] EITS_IDX_IRQ2_CTRL  = 16'h7071;
	localparam logic [15:0] EITS_IDX_NMI_CTRL   = 16'h7077;
	localparam logic [15:0] EITS_IDX_IRQ1_STAMP = 16'h7078;
	localparam logic [15:0] EITS_IDX_IRQ2_STAMP = 16'h7079;
	localparam logic [15:0] EITS_IDX_NMI_STAMP  = 16'h707f;
	localparam logic [15:0] EITS_IDX_IRQ_STATUS = 16'h7080;
	localparam logic [15:0] EITS_IDX_IRQ_MASK   = 16'h7081;
	// Control register fields
	localparam int          EITS_BIT_ENABLE     = 0;
	localparam int          EITS_BIT_SELECT     = 1;
	localparam int          EITS_BIT_POLARITY   = 2;
	localparam int          EITS_CTRL_W         = 3;
	localparam logic [2:0]  EITS_CTRL_RST       = 3'h0;
	localparam logic [2:0]  EITS_XINT_CTRL_MASK = 3'h5;
	localparam logic [2:0]  EITS_NMI_CTRL_MASK  = 3'h7;
	// Counter and source count
	localparam int          EITS_CNT_W          = 16;
	localparam logic [15:0] EITS_CNT_RST        = 16'h0000;
	localparam int          EITS_NSRC           = 3;
	localparam logic [2:0]  EITS_STAT_RST       = 3'h0;
	// Source indices
	localparam int          EITS_SRC_A          = 0;
	localparam int          EITS_SRC_B          = 1;
	localparam int          EITS_SRC_NMI        = 2;
endpackage : eits_pkg

// file: include/eits_chan_if.sv
// Bundle between the top and one edge channel.
// Assumes one system clock shared by both ends.
`timescale 1ns/10ps
interface eits_chan_if;
	logic        pin;
	logic        enable;
	logic        polarity;
	logic        edge_pulse;
	logic [15:0] count;
	// Top side drives pin and control, reads results
	modport ctrl (output pin, output enable, output polarity, input edge_pulse, input count);
	// Channel side
	modport chan (input pin, input enable, input polarity, output edge_pulse, output count);
endinterface : eits_chan_if

// file: rtl/eits_sync.sv
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin is free of glitches shorter than a clock period.
`timescale 1ns/10ps
module eits_sync (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Pin and synchronised level
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_r;

	// First stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : eits_sync

// file: rtl/eits_chan.sv
// One input channel: synchroniser, edge detect, time-stamp counter.
// Assumes control bits come from registers in the same clock domain.
`timescale 1ns/10ps
module eits_chan (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Channel bundle
	eits_chan_if.chan ch
);
	logic                          pin_s;
	logic                          prev_r;
	logic [eits_pkg::EITS_CNT_W-1:0] cnt_r;
	logic                          rise;
	logic                          fall;
	logic                          hit;

	eits_sync u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (ch.pin),
		.sync_out (pin_s)
	);

	// Edge qualification against chosen polarity
	assign rise = pin_s & ~prev_r;
	assign fall = ~pin_s & prev_r;
	assign hit  = ch.polarity ? rise : fall;

	// Previous sample and counter
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prev_r <= 1'b0;
			cnt_r  <= eits_pkg::EITS_CNT_RST;
		end else begin
			prev_r <= pin_s;
			if (ch.enable && hit)
				cnt_r <= eits_pkg::EITS_CNT_RST;
			else if (ch.enable)
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	assign ch.count      = cnt_r;
	assign ch.edge_pulse = ch.enable & hit;
endmodule : eits_chan

// file: rtl/eits_top.sv
// External interrupt unit with per-pin edge time-stamp counters.
// Assumes a classic Wishbone master on sys_clk and asynchronous pins.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Bit 0 of each maskable control register enables that pin interrupt.
// - Bit 2 of every control register picks rising (1) or falling (0) edges.
// - Bit 0 of the non-maskable control register enables that interrupt.
// - Bit 1 of the non-maskable control register routes line thirteen from pin or timer.
// - Unused control bits always read as zero.
// - Each input owns a 16-bit counter advancing every clock while its input is enabled.
// - A valid edge clears the counter, which then resumes counting.
// - Only the selected edge polarity clears the counter.
// - A disabled input holds its counter.
// - The counter wraps from all ones to zero.
// - Counters are read-only and cleared only by valid edge or reset.
// - Control registers sit at word addresses 7070, 7071 and 7077.
// - Counters sit at word addresses 7078, 7079 and 707f.
module eits_top (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// Interrupt pins
	input  wire logic        ext_irq_pin_a,
	input  wire logic        ext_irq_pin_b,
	input  wire logic        nonmaskable_pin,
	// Timer source for line thirteen
	input  wire logic        timer1_irq,
	// Requests toward the CPU
	output logic             ext_irq_a_req,
	output logic             ext_irq_b_req,
	output logic             nonmaskable_req,
	output logic             cpu_irq_line_thirteen,
	// Summary interrupt
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////
	// Registers and wires
	logic [2:0]  ext_irq1_control_r;
	logic [2:0]  ext_irq2_control_r;
	logic [2:0]  nonmaskable_pin_control_r;
	logic [2:0]  irq_status_r;
	logic [2:0]  irq_mask_r;
	logic        ack_r;
	logic        err_r;
	logic [31:0] dat_r;
	logic [15:0] word_idx;
	logic        req;
	logic        wr_lo;
	logic        hit_c1;
	logic        hit_c2;
	logic        hit_cn;
	logic        hit_t1;
	logic        hit_t2;
	logic        hit_tn;
	logic        hit_st;
	logic        hit_mk;
	logic        mapped;
	logic [2:0]  wr_bits;
	logic [2:0]  edges;
	logic [31:0] rd_mux;

	// Write strobes and bus next values
	logic        wr_c1;
	logic        wr_c2;
	logic        wr_cn;
	logic        wr_st;
	logic        wr_mk;
	logic        rd_en;
	logic        ack_nxt;
	logic        err_nxt;
	logic [31:0] dat_nxt;

	// Read words
	logic [31:0] rd_c1;
	logic [31:0] rd_c2;
	logic [31:0] rd_cn;
	logic [31:0] rd_t1;
	logic [31:0] rd_t2;
	logic [31:0] rd_tn;
	logic [31:0] rd_st;
	logic [31:0] rd_mk;

	// Control and status next values
	logic [2:0]  ctrl_a_nxt;
	logic [2:0]  ctrl_b_nxt;
	logic [2:0]  ctrl_n_nxt;
	logic [2:0]  irq_status_nxt;
	logic [2:0]  irq_pending;
	logic        line_sel;

	// Decode groups
	logic        hit_ctrl;
	logic        hit_stamp;
	logic        hit_own;

	////////////////////////////////////////////////////////////////////////
	// Channel bundles
	eits_chan_if ch_a ();
	eits_chan_if ch_b ();
	eits_chan_if ch_n ();
	// One bundle per input; the channel drives pulse and count,
	// this level drives the pin and the two control bits

	////////////////////////////////////////////////////////////////////////
	// Channels
	// Pin a: maskable input
	// A disabled channel still tracks its pin, so enabling gives no false edge
	assign ch_a.pin      = ext_irq_pin_a;
	assign ch_a.enable   = ext_irq1_control_r[eits_pkg::EITS_BIT_ENABLE];
	assign ch_a.polarity = ext_irq1_control_r[eits_pkg::EITS_BIT_POLARITY];

	// Pin b: maskable input
	assign ch_b.pin      = ext_irq_pin_b;
	assign ch_b.enable   = ext_irq2_control_r[eits_pkg::EITS_BIT_ENABLE];
	assign ch_b.polarity = ext_irq2_control_r[eits_pkg::EITS_BIT_POLARITY];

	// Nonmaskable input
	assign ch_n.pin      = nonmaskable_pin;
	assign ch_n.enable   = nonmaskable_pin_control_r[eits_pkg::EITS_BIT_ENABLE];
	assign ch_n.polarity = nonmaskable_pin_control_r[eits_pkg::EITS_BIT_POLARITY];

	// Channel a
	eits_chan u_chan_a (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ch      (ch_a)
	);

	// Channel b
	eits_chan u_chan_b (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ch      (ch_b)
	);

	// Nonmaskable channel
	eits_chan u_chan_n (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ch      (ch_n)
	);

	////////////////////////////////////////////////////////////////////////
	// Request outputs and line thirteen routing
	// A pin change reaches the synchroniser output two edges later and is
	// qualified against the previous sample in the cycle after; the request
	// pulse lasts that one cycle and the counter reads zero after it
	assign ext_irq_a_req   = ch_a.edge_pulse;
	assign ext_irq_b_req   = ch_b.edge_pulse;
	assign nonmaskable_req = ch_n.edge_pulse;

	// Line thirteen: nonmaskable pulse when selected, timer otherwise
	// Timer level passes straight through, with no qualification
	assign line_sel = nonmaskable_pin_control_r[eits_pkg::EITS_BIT_SELECT];
	assign cpu_irq_line_thirteen = line_sel ? ch_n.edge_pulse : timer1_irq;

	// Edge pulses feed the sticky status
	assign edges = {ch_n.edge_pulse, ch_b.edge_pulse, ch_a.edge_pulse};

	////////////////////////////////////////////////////////////////////////
	// Address decode
	// Byte address in, word index from bits 17 down to 2
	// Register map by word index:
	//   7070  control, pin a (enable, polarity)
	//   7071  control, pin b (enable, polarity)
	//   7077  control, nonmaskable (enable, select, polarity)
	//   7078  time stamp, pin a (read only)
	//   7079  time stamp, pin b (read only)
	//   707f  time stamp, nonmaskable (read only)
	//   7080  sticky status, write one to clear
	//   7081  interrupt mask
	// Any other index answers with err and changes nothing
	assign word_idx = wb_adr_i[17:2];
	assign req      = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
	assign rd_en    = req & ~wb_we_i;
	// Only byte lane zero carries control bits; without it a write is dropped
	// Write lands at the edge where the master samples ack, request still held
	assign wr_lo    = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ack_r;
	assign hit_c1   = word_idx == eits_pkg::EITS_IDX_IRQ1_CTRL;
	assign hit_c2   = word_idx == eits_pkg::EITS_IDX_IRQ2_CTRL;
	assign hit_cn   = word_idx == eits_pkg::EITS_IDX_NMI_CTRL;
	assign hit_t1   = word_idx == eits_pkg::EITS_IDX_IRQ1_STAMP;
	assign hit_t2   = word_idx == eits_pkg::EITS_IDX_IRQ2_STAMP;
	assign hit_tn   = word_idx == eits_pkg::EITS_IDX_NMI_STAMP;
	assign hit_st   = word_idx == eits_pkg::EITS_IDX_IRQ_STATUS;
	assign hit_mk   = word_idx == eits_pkg::EITS_IDX_IRQ_MASK;

	// Decode groups; anything else is unmapped
	assign hit_ctrl  = hit_c1 | hit_c2 | hit_cn;
	assign hit_stamp = hit_t1 | hit_t2 | hit_tn;
	assign hit_own   = hit_st | hit_mk;
	assign mapped    = hit_ctrl | hit_stamp | hit_own;
	assign wr_bits   = wb_dat_i[2:0];

	// Per-register write strobes, none for the time stamps
	assign wr_c1    = wr_lo & hit_c1;
	assign wr_c2    = wr_lo & hit_c2;
	assign wr_cn    = wr_lo & hit_cn;
	assign wr_st    = wr_lo & hit_st;
	assign wr_mk    = wr_lo & hit_mk;

	// Read words, unused bits zero
	// Counters read live: a read shows the count at the taking edge
	assign rd_c1 = {29'h0, ext_irq1_control_r};
	assign rd_c2 = {29'h0, ext_irq2_control_r};
	assign rd_cn = {29'h0, nonmaskable_pin_control_r};
	assign rd_t1 = {16'h0, ch_a.count};
	assign rd_t2 = {16'h0, ch_b.count};
	assign rd_tn = {16'h0, ch_n.count};
	assign rd_st = {29'h0, irq_status_r};
	assign rd_mk = {29'h0, irq_mask_r};

	// Read selection by decoded index
	assign rd_mux =
		hit_c1 ? rd_c1 :
		hit_c2 ? rd_c2 :
		hit_cn ? rd_cn :
		hit_t1 ? rd_t1 :
		hit_t2 ? rd_t2 :
		hit_tn ? rd_tn :
		hit_st ? rd_st :
		hit_mk ? rd_mk : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// Bus answer, one wait state
	// Taken at the first edge with cyc and stb high and no answer pending
	// Ack or err then stands for exactly one cycle
	// Read data stands only with ack, zero otherwise
	// Back-to-back requests need the answer cycle between them
	assign ack_nxt = req & mapped;
	assign err_nxt = req & ~mapped;
	assign dat_nxt = (rd_en & mapped) ? rd_mux : 32'h0;

	// Acknowledge for mapped indices
	always_ff @(posedge sys_clk) begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= ack_nxt;
	end

	// Error for unmapped indices, no side effect
	always_ff @(posedge sys_clk) begin
		if (rst)
			err_r <= 1'b0;
		else
			err_r <= err_nxt;
	end

	// Read data register
	always_ff @(posedge sys_clk) begin
		if (rst)
			dat_r <= 32'h0;
		else
			dat_r <= dat_nxt;
	end

	// Bus outputs straight from flip-flops
	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;
	assign wb_dat_o = dat_r;

	////////////////////////////////////////////////////////////////////////
	// Control registers; counters take no writes
	// After reset all inputs are disabled, falling edges selected
	// and line thirteen follows the timer
	// Next values keep only implemented bits, reserved bits stay zero
	assign ctrl_a_nxt = wr_bits & eits_pkg::EITS_XINT_CTRL_MASK;
	assign ctrl_b_nxt = wr_bits & eits_pkg::EITS_XINT_CTRL_MASK;
	assign ctrl_n_nxt = wr_bits & eits_pkg::EITS_NMI_CTRL_MASK;

	// Pin a control: enable, polarity
	// Enable gates both the request and the counter of pin a
	always_ff @(posedge sys_clk) begin
		if (rst)
			ext_irq1_control_r <= eits_pkg::EITS_CTRL_RST;
		else if (wr_c1)
			ext_irq1_control_r <= ctrl_a_nxt;
	end

	// Pin b control: enable, polarity
	// Enable gates both the request and the counter of pin b
	always_ff @(posedge sys_clk) begin
		if (rst)
			ext_irq2_control_r <= eits_pkg::EITS_CTRL_RST;
		else if (wr_c2)
			ext_irq2_control_r <= ctrl_b_nxt;
	end

	// Nonmaskable control: enable, select, polarity
	// Select only steers line thirteen; the request output is unaffected
	always_ff @(posedge sys_clk) begin
		if (rst)
			nonmaskable_pin_control_r <= eits_pkg::EITS_CTRL_RST;
		else if (wr_cn)
			nonmaskable_pin_control_r <= ctrl_n_nxt;
	end

	// Interrupt mask: bit 0 pin a, bit 1 pin b, bit 2 nonmaskable
	// Masking hides a bit from irq but leaves it readable
	always_ff @(posedge sys_clk) begin
		if (rst)
			irq_mask_r <= eits_pkg::EITS_STAT_RST;
		else if (wr_mk)
			irq_mask_r <= wr_bits;
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status, set wins over write-one clear
	// Bits set only on enabled qualified edges
	// An edge in the cycle of its own clear keeps the bit set,
	// so software never loses an event that raced the write
	for (genvar s = 0; s < eits_pkg::EITS_NSRC; s++) begin : g_status
		assign irq_status_nxt[s] = edges[s] | (irq_status_r[s] & ~(wr_st & wr_bits[s]));
	end

	// Status register
	always_ff @(posedge sys_clk) begin
		if (rst)
			irq_status_r <= eits_pkg::EITS_STAT_RST;
		else
			irq_status_r <= irq_status_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Level interrupt from unmasked status bits
	// Stays high until software clears or masks every pending bit
	assign irq_pending = irq_status_r & irq_mask_r;
	assign irq         = |irq_pending;
endmodule : eits_top

// file: sim/eits_properties.sv
// Port checker for the edge time-stamp unit.
// Assumes it is bound onto eits_top, one clock, synchronous reset.
`timescale 1ns/10ps
module eits_properties (
	// Clock, reset and bus
	input wire logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o,
	input wire logic [31:0] wb_dat_o,
	// Requests and interrupt
	input wire logic        ext_irq_a_req, ext_irq_b_req, nonmaskable_req,
	input wire logic        cpu_irq_line_thirteen, timer1_irq, irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// Bus steps
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
	sequence s_answer; wb_ack_o || wb_err_o; endsequence
	a_answer_next: assert property (s_take |=> s_answer) else $error("no answer");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
	////////////////////////////////////////////////////////////////////////////////
	// Requests
	a_a_pulse: assert property (ext_irq_a_req |=> !ext_irq_a_req) else $error("a");
	a_b_pulse: assert property (ext_irq_b_req |=> !ext_irq_b_req) else $error("b");
	a_nmi_pulse: assert property (nonmaskable_req |=> !nonmaskable_req) else $error("n");
	a_line_source: assert property (cpu_irq_line_thirteen |-> timer1_irq || nonmaskable_req)
		else $error("line");
	a_irq_quiet: assert property ($fell(rst) |-> !irq && !wb_ack_o) else $error("reset");
endmodule : eits_properties

bind eits_top eits_properties chk_u (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wb_dat_o(wb_dat_o),
	.ext_irq_a_req(ext_irq_a_req), .ext_irq_b_req(ext_irq_b_req),
	.nonmaskable_req(nonmaskable_req), .cpu_irq_line_thirteen(cpu_irq_line_thirteen),
	.timer1_irq(timer1_irq), .irq(irq));

// file: sim/eits_pin_src.sv
// External sources driving the three interrupt pins.
// Assumes the bench calls set to move one pin after a rising edge.
`timescale 1ns/10ps
module eits_pin_src (
	// Clock
	input wire logic sys_clk,
	// Pin levels
	output logic [2:0] pins
);
	initial pins = 3'h0;
	// Move one pin just after a rising edge
	task set(input int i, input logic v);
		@(posedge sys_clk);
		pins[i] <= v;
	endtask : set
endmodule : eits_pin_src

// file: sim/eits_top_bench.sv
// Bench for the edge time-stamp unit: registers, pins, interrupt.
// Assumes eits_top, eits_pin_src and the bound checker.
`timescale 1ns/10ps
module eits_top_bench;
	logic        sys_clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, tmr = 1'b0;
	logic [17:0] adr = 18'h0;
	logic [31:0] wdat = 32'h0, rdat, q, q2;
	logic        ack, err, irq, l13, qa, qb, qn, e, h;
	logic [2:0]  pins;
	int          n_mismatch = 0, samples_checked = 0;
	always #20 sys_clk = ~sys_clk;
	eits_pin_src src_u (.sys_clk(sys_clk), .pins(pins));
	eits_top dut_u (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]),
		.nonmaskable_pin(pins[2]), .timer1_irq(tmr), .ext_irq_a_req(qa),
		.ext_irq_b_req(qb), .nonmaskable_req(qn), .cpu_irq_line_thirteen(l13), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Compares
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t word %h want %h", $time, got, exp);
		end
	endtask : chk
	task chkb(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t flag %b want %b", $time, got, exp);
		end
	endtask : chkb
	// One classic cycle, held until ack or err
	task wb(input logic w, input logic [15:0] i, input logic [31:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		wdat <= d;
		// Wait for the answer; only the watchdog ends a hung cycle
		do begin
			@(posedge sys_clk);
		end while (ack !== 1'b1 && err !== 1'b1);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb
	// Watch requests and line thirteen for eight cycles
	task hit(input logic [3:0] m);
		h = 1'b0;
		repeat (8) begin
			@(negedge sys_clk);
			if (({l13, qn, qb, qa} & m) != 4'h0) h = 1'b1;
		end
	endtask : hit
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_regs;
		wb(0, 16'h7070, 0);
		chk(q, 32'h0);
		wb(1, 16'h707f, 32'hffff);
		wb(0, 16'h707f, 0);
		chk(q, 32'h0);
		wb(1, 16'h7070, 32'hffff);
		wb(0, 16'h7070, 0);
		chk(q, 32'h5);
		wb(1, 16'h7071, 32'hffff);
		wb(0, 16'h7071, 0);
		chk(q, 32'h5);
		wb(1, 16'h7077, 32'hffff);
		wb(0, 16'h7077, 0);
		chk(q, 32'h7);
		wb(0, 16'h7072, 0);
		chkb(e, 1'b1);
		wb(1, 16'h7070, 0);
		wb(1, 16'h7071, 0);
		wb(1, 16'h7077, 0);
		$display("regs done");
	endtask : t_regs
	task t_edge;
		wb(1, 16'h7070, 32'h5);
		src_u.set(0, 1'b1);
		hit(4'h1);
		chkb(h, 1'b1);
		wb(0, 16'h7078, 0);
		chkb(q < 16, 1'b1);
		q2 = q;
		src_u.set(0, 1'b0);
		hit(4'h1);
		chkb(h, 1'b0);
		wb(0, 16'h7078, 0);
		chk(q - q2, 32'hb);
		$display("edge done");
	endtask : t_edge
	task t_fall;
		wb(1, 16'h7071, 32'h1);
		src_u.set(1, 1'b1);
		hit(4'h2);
		chkb(h, 1'b0);
		src_u.set(1, 1'b0);
		hit(4'h2);
		chkb(h, 1'b1);
		wb(0, 16'h7079, 0);
		chkb(q < 16, 1'b1);
		$display("fall done");
	endtask : t_fall
	task t_hold;
		wb(1, 16'h7070, 0);
		wb(0, 16'h7078, 0);
		q2 = q;
		src_u.set(0, 1'b1);
		hit(4'h1);
		chkb(h, 1'b0);
		wb(0, 16'h7078, 0);
		chk(q, q2);
		wb(1, 16'h7070, 32'h5);
		wb(0, 16'h7078, 0);
		q2 = q;
		repeat (65533) @(posedge sys_clk); // Full wrap between the two samples
		wb(0, 16'h7078, 0);
		chk(q, q2);
		$display("hold done");
	endtask : t_hold
	task t_irq;
		wb(1, 16'h7080, 32'h7);
		wb(1, 16'h7081, 0);
		src_u.set(1, 1'b1);
		src_u.set(1, 1'b0);
		hit(4'h2);
		chkb(h, 1'b1);
		chkb(irq, 1'b0);
		wb(0, 16'h7080, 0);
		chk(q, 32'h2);
		wb(1, 16'h7081, 32'h2);
		@(negedge sys_clk);
		chkb(irq, 1'b1);
		wb(1, 16'h7080, 32'h2);
		@(negedge sys_clk);
		chkb(irq, 1'b0);
		$display("irq done");
	endtask : t_irq
	task t_nmi;
		@(posedge sys_clk);
		tmr <= 1'b1;
		@(negedge sys_clk);
		chkb(l13, 1'b1);
		wb(1, 16'h7077, 32'h7);
		@(negedge sys_clk);
		chkb(l13, 1'b0);
		src_u.set(2, 1'b1);
		hit(4'h8);
		chkb(h, 1'b1);
		$display("nmi done");
	endtask : t_nmi
	////////////////////////////////////////////////////////////////////////////////
	// Verdict and run control
	task conclude;
		$display("checked %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	initial begin
		#(40 * 90000);
		n_mismatch++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_edge;
		t_fall;
		t_hold;
		t_irq;
		t_nmi;
		conclude;
	end
endmodule : eits_top_bench
